/* File: core/serdes_align_pkg.sv */
// Constants shared by the receive alignment control block
package serdes_align_pkg;
  // Channel count and bus widths
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_SYNC_LOCK = 20'h3_0800;
  localparam logic [ADDR_W-1:0] OFS_LOOP_WALIGN = 20'h3_0801;
  localparam logic [ADDR_W-1:0] OFS_LINK_SM = 20'h3_0802;
  localparam logic [ADDR_W-1:0] OFS_LOCK_STAT = 20'h3_0805;
  localparam logic [ADDR_W-1:0] OFS_REALIGN_PART = 20'h3_0810;
  localparam logic [ADDR_W-1:0] OFS_SYNC_MODE = 20'h3_0811;
  localparam logic [ADDR_W-1:0] OFS_RESYNC_LINK = 20'h3_0820;

  // Reset values
  localparam logic [7:0] RST_SYNC_LOCK = 8'h00;
  localparam logic [7:0] RST_LOOP_WALIGN = 8'h00;
  localparam logic [3:0] RST_LINK_SM = 4'h0;
  localparam logic [7:0] RST_REALIGN_PART = 8'h00;
  localparam logic [7:0] RST_SYNC_MODE = 8'h00;
  localparam logic [7:0] RST_RESYNC_LINK = 8'h00;

  // Field positions
  localparam int BYTE_SYNC_LSB = 0;
  localparam int LOCK_SRC_LSB = 4;
  localparam int LOOP_LSB = 0;
  localparam int WALIGN_LSB = 4;
  localparam int REALIGN_LSB = 0;
  localparam int PART_LSB = 4;
  localparam int RESYNC1_LSB = 0;
  localparam int RESYNC2_LSB = 4;
  localparam int RESYNC4_BIT = 6;
  localparam int QUAD_LINK_BIT = 7;

  // Alignment grouping codes, two bits per channel
  localparam logic [1:0] SYNC_NONE = 2'h0;
  localparam logic [1:0] SYNC_TWIN = 2'h2;
  localparam logic [1:0] SYNC_QUAD = 2'h1;
  localparam logic [1:0] SYNC_UNUSED = 2'h3;

  // Edge detector width: realign, single, pair and group requests
  localparam int EDGE_W = 11;
endpackage

/* File: core/edge_pulse.sv */
// Rising edge detector giving one-cycle pulses per bit
`timescale 1ns/1ns
`default_nettype none
module edge_pulse #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Levels in, pulses out
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] pulse
);
  logic [WIDTH-1:0] prevQ;
  logic [WIDTH-1:0] pulseQ;

  // Previous value of each level
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      prevQ <= '0;
    else
      prevQ <= level;
  end

  // Pulse when a bit is high now and was low before
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pulseQ <= '0;
    else
      pulseQ <= level & ~prevQ;
  end

  assign pulse = pulseQ;
endmodule
`default_nettype wire

/* File: core/serdes_quad_rx_align_control.sv */
// Register file and control outputs for quad receive alignment
// Function
// - Each channel has a byte sync enable bit, channels A to D at bits 0 to 3.
// - The lock source bit per channel, bits 4 to 7, picks reference clock at 0 or data at 1.
// - A channel locked to the reference clock reports its lock indicator as zero.
// - A set loopback bit routes the channel's transmit output into its receiver.
// - While loopback is on, the channel's external serial output is disabled.
// - A set word align disable bit, bits 4 to 7, suppresses word alignment on that channel.
// - A rising realign bit makes the channel realign on the next comma, a steady level does nothing.
// - The two-bit sync mode selects none at 00, twin at 10 and quad at 01, with 11 unassigned.
// - A rising single resync bit resets that channel's buffer write and read pointers.
// - A rising pair resync bit resyncs A and B from bit 4, or C and D from bit 5.
// - A rising group resync bit at bit 6 resyncs all four channels.
// - With the quad link selector at bit 7 set, all channels use the XAUI link machine.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module serdes_quad_rx_align_control
  import serdes_align_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  // Receiver PLL lock detect from the lanes
  input wire logic [NUM_CH-1:0] pllLockDetect,
  // Receiver controls
  output logic [NUM_CH-1:0] byteSyncEnable,
  output logic [NUM_CH-1:0] lockToData,
  output logic [NUM_CH-1:0] lockIndicator,
  output logic [NUM_CH-1:0] wordAlignDisable,
  output logic [NUM_CH-1:0] wordRealignPulse,
  // Loopback and serial output
  output logic [NUM_CH-1:0] serialLoopbackEnable,
  output logic [NUM_CH-1:0] serialTxEnable,
  // Multi-channel alignment
  output logic [NUM_CH-1:0] multichanParticipate,
  output logic [NUM_CH-1:0] twinAlign,
  output logic [NUM_CH-1:0] quadAlign,
  output logic [NUM_CH-1:0] alignResyncPulse,
  // Link state machine choice, 1 = XAUI
  output logic [NUM_CH-1:0] xauiLinkSelect
);
  // Register bits
  logic [7:0] syncLockQ;
  logic [7:0] loopAlignQ;
  logic [3:0] linkSmQ;
  logic [7:0] realignPartQ;
  logic [7:0] syncModeQ;
  logic [7:0] resyncLinkQ;
  // Derived flops
  logic [NUM_CH-1:0] txEnQ;
  logic [NUM_CH-1:0] lockSync1Q;
  logic [NUM_CH-1:0] lockSync2Q;
  logic [NUM_CH-1:0] lockIndQ;
  logic [NUM_CH-1:0] twinQ;
  logic [NUM_CH-1:0] quadQ;
  logic [NUM_CH-1:0] resyncQ;
  logic [NUM_CH-1:0] xauiQ;
  logic [DATA_W-1:0] rdDataQ;
  // Edge detector wiring
  logic [EDGE_W-1:0] edgeLevel;
  logic [EDGE_W-1:0] edgePulse;
  logic [NUM_CH-1:0] singlePulse;
  logic [1:0] pairPulse;
  logic groupPulse;
  // Decoded strobes
  logic wrSyncLock;
  logic wrLoopAlign;
  logic wrLinkSm;
  logic wrRealignPart;
  logic wrSyncMode;
  logic wrResyncLink;

  // Address match
  function automatic logic addrHit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    addrHit = (addr == ofs);
  endfunction
  // Sync mode field test for one channel
  function automatic logic modeIs(input logic [7:0] modes, input int ch, input logic [1:0] code);
    modeIs = (modes[2*ch +: 2] == code);
  endfunction

  // Write decode
  assign wrSyncLock = regWr && addrHit(regAddr, OFS_SYNC_LOCK);
  assign wrLoopAlign = regWr && addrHit(regAddr, OFS_LOOP_WALIGN);
  assign wrLinkSm = regWr && addrHit(regAddr, OFS_LINK_SM);
  assign wrRealignPart = regWr && addrHit(regAddr, OFS_REALIGN_PART);
  assign wrSyncMode = regWr && addrHit(regAddr, OFS_SYNC_MODE);
  assign wrResyncLink = regWr && addrHit(regAddr, OFS_RESYNC_LINK);

  // Byte sync enable and lock source register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      syncLockQ <= RST_SYNC_LOCK;
    else if (wrSyncLock)
      syncLockQ <= regWrData;
  end

  // Loopback and word align disable register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      loopAlignQ <= RST_LOOP_WALIGN;
    else if (wrLoopAlign)
      loopAlignQ <= regWrData;
  end

  // Serial output enable, updated with the loopback bits so both never overlap
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      txEnQ <= 4'hF;
    else if (wrLoopAlign)
      txEnQ <= ~regWrData[LOOP_LSB +: NUM_CH];
  end

  // Per-channel link machine selects
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      linkSmQ <= RST_LINK_SM;
    else if (wrLinkSm)
      linkSmQ <= regWrData[NUM_CH-1:0];
  end

  // Realign request and participation register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      realignPartQ <= RST_REALIGN_PART;
    else if (wrRealignPart)
      realignPartQ <= regWrData;
  end

  // Sync mode register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      syncModeQ <= RST_SYNC_MODE;
    else if (wrSyncMode)
      syncModeQ <= regWrData;
  end

  // Resync requests and quad link selector
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      resyncLinkQ <= RST_RESYNC_LINK;
    else if (wrResyncLink)
      resyncLinkQ <= regWrData;
  end

  // Rising edges of realign and resync levels
  assign edgeLevel = {resyncLinkQ[RESYNC4_BIT],
                      resyncLinkQ[RESYNC2_LSB +: 2],
                      resyncLinkQ[RESYNC1_LSB +: NUM_CH],
                      realignPartQ[REALIGN_LSB +: NUM_CH]};

  edge_pulse #(
    .WIDTH(EDGE_W)
  ) u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level(edgeLevel),
    .pulse(edgePulse)
  );

  assign singlePulse = edgePulse[NUM_CH +: NUM_CH];
  assign pairPulse = edgePulse[2*NUM_CH +: 2];
  assign groupPulse = edgePulse[2*NUM_CH+2];

  // Buffer pointer reset per channel from single, pair or group requests
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      resyncQ <= 4'h0;
    else
      resyncQ <= singlePulse
        | {{2{pairPulse[1]}}, {2{pairPulse[0]}}}
        | {NUM_CH{groupPulse}};
  end

  // Lock detect comes from the analog lanes, so synchronise it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lockSync1Q <= 4'h0;
      lockSync2Q <= 4'h0;
    end
    else
    begin
      lockSync1Q <= pllLockDetect;
      lockSync2Q <= lockSync1Q;
    end
  end

  // Lock indicator low on reference lock, a written source applies at once so it never lags
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      lockIndQ <= 4'h0;
    else if (wrSyncLock)
      lockIndQ <= lockSync2Q & regWrData[LOCK_SRC_LSB +: NUM_CH];
    else
      lockIndQ <= lockSync2Q & syncLockQ[LOCK_SRC_LSB +: NUM_CH];
  end

  // Alignment grouping, only for participating channels
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      twinQ <= 4'h0;
      quadQ <= 4'h0;
    end
    else
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        twinQ[ch] <= realignPartQ[PART_LSB+ch] && modeIs(syncModeQ, ch, SYNC_TWIN);
        quadQ[ch] <= realignPartQ[PART_LSB+ch] && modeIs(syncModeQ, ch, SYNC_QUAD);
      end
    end
  end

  // Link machine choice, quad selector overrides per-channel bits
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      xauiQ <= 4'h0;
    else if (resyncLinkQ[QUAD_LINK_BIT])
      xauiQ <= 4'hF;
    else
      xauiQ <= linkSmQ;
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdDataQ <= 8'h00;
    else if (!regRd)
      rdDataQ <= 8'h00;
    else
    begin
      case (regAddr)
        OFS_SYNC_LOCK: rdDataQ <= syncLockQ;
        OFS_LOOP_WALIGN: rdDataQ <= loopAlignQ;
        OFS_LINK_SM: rdDataQ <= {4'h0, linkSmQ};
        OFS_LOCK_STAT: rdDataQ <= {4'h0, lockIndQ};
        OFS_REALIGN_PART: rdDataQ <= realignPartQ;
        OFS_SYNC_MODE: rdDataQ <= syncModeQ;
        OFS_RESYNC_LINK: rdDataQ <= resyncLinkQ;
        default: rdDataQ <= 8'h00; // Unmapped reads as zero
      endcase
    end
  end

  // Outputs straight from flops
  assign regRdData = rdDataQ;
  assign byteSyncEnable = syncLockQ[BYTE_SYNC_LSB +: NUM_CH];
  assign lockToData = syncLockQ[LOCK_SRC_LSB +: NUM_CH];
  assign lockIndicator = lockIndQ;
  assign serialLoopbackEnable = loopAlignQ[LOOP_LSB +: NUM_CH];
  assign serialTxEnable = txEnQ;
  assign wordAlignDisable = loopAlignQ[WALIGN_LSB +: NUM_CH];
  assign wordRealignPulse = edgePulse[NUM_CH-1:0];
  assign multichanParticipate = realignPartQ[PART_LSB +: NUM_CH];
  assign twinAlign = twinQ;
  assign quadAlign = quadQ;
  assign alignResyncPulse = resyncQ;
  assign xauiLinkSelect = xauiQ;

  // Byte sync bits follow a write
  property p_byteSync;
    @(posedge core_clk) disable iff (!rst_n)
      wrSyncLock |=> byteSyncEnable == $past(regWrData[3:0]);
  endproperty
  a_byteSync: assert property (p_byteSync) else $error("byte sync enable not written");
  // Lock source bits follow a write
  property p_lockSrc;
    @(posedge core_clk) disable iff (!rst_n)
      wrSyncLock |=> lockToData == $past(regWrData[7:4]);
  endproperty
  a_lockSrc: assert property (p_lockSrc) else $error("lock source not written");
  // No lock indication while locked to reference clock
  property p_lockInd;
    @(posedge core_clk) disable iff (!rst_n)
      (lockIndicator & ~lockToData) == 4'h0;
  endproperty
  a_lockInd: assert property (p_lockInd) else $error("lock indicator set on reference lock");
  // Loopback bits follow a write
  property p_loop;
    @(posedge core_clk) disable iff (!rst_n)
      wrLoopAlign |=> serialLoopbackEnable == $past(regWrData[3:0]);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback not written");
  // Serial output off exactly where loopback is on
  property p_txOff;
    @(posedge core_clk) disable iff (!rst_n)
      serialTxEnable == ~serialLoopbackEnable;
  endproperty
  a_txOff: assert property (p_txOff) else $error("serial output enabled during loopback");
  // Word align disable follows a write
  property p_walign;
    @(posedge core_clk) disable iff (!rst_n)
      wrLoopAlign |=> wordAlignDisable == $past(regWrData[7:4]);
  endproperty
  a_walign: assert property (p_walign) else $error("word align disable not written");
  // Realign pulse one cycle after a rising request, one cycle long
  property p_realign;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(realignPartQ[0]) |=> wordRealignPulse[0] ##1 !wordRealignPulse[0];
  endproperty
  a_realign: assert property (p_realign) else $error("realign pulse wrong");
  // Steady realign level gives no pulse
  property p_realignStatic;
    @(posedge core_clk) disable iff (!rst_n)
      $stable(realignPartQ[0]) |=> !wordRealignPulse[0];
  endproperty
  a_realignStatic: assert property (p_realignStatic) else $error("realign without edge");
  // No grouping without participation, never both groupings
  property p_group;
    @(posedge core_clk) disable iff (!rst_n)
      ((twinAlign | quadAlign) & ~$past(multichanParticipate)) == 4'h0 && (twinAlign & quadAlign) == 4'h0;
  endproperty
  a_group: assert property (p_group) else $error("alignment grouping wrong");
  // Twin code on a participating channel selects twin alignment
  property p_twin;
    @(posedge core_clk) disable iff (!rst_n)
      realignPartQ[PART_LSB] && syncModeQ[1:0] == SYNC_TWIN |=> twinAlign[0];
  endproperty
  a_twin: assert property (p_twin) else $error("twin mode not decoded");
  // Single resync reaches its channel two cycles after the rise
  property p_single;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(resyncLinkQ[1]) |-> ##2 alignResyncPulse[1];
  endproperty
  a_single: assert property (p_single) else $error("single resync missing");
  // Pair resync reaches both channels C and D
  property p_pair;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(resyncLinkQ[5]) |-> ##2 alignResyncPulse[3:2] == 2'h3;
  endproperty
  a_pair: assert property (p_pair) else $error("pair resync missing");
  // Group resync reaches all channels
  property p_all;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(resyncLinkQ[RESYNC4_BIT]) |-> ##2 alignResyncPulse == 4'hF;
  endproperty
  a_all: assert property (p_all) else $error("group resync missing");
  // Quad selector forces XAUI on every channel
  property p_xaui;
    @(posedge core_clk) disable iff (!rst_n)
      resyncLinkQ[QUAD_LINK_BIT] |=> xauiLinkSelect == 4'hF;
  endproperty
  a_xaui: assert property (p_xaui) else $error("quad link select ignored");
endmodule
`default_nettype wire

/* File: tb/lane_peer.sv */
// Far-end lane model that reports receiver PLL lock for each channel
`timescale 1ns/1ns
`default_nettype none
module lane_peer #(
  parameter int LOCK_DLY = 12
) (
  // Clock
  input wire logic core_clk,
  // Lock source chosen by the block
  input wire logic [3:0] lockToData,
  // Lock reported to the block
  output logic [3:0] pllLockDetect
);
  int cnt [4];

  // Reference lock holds at once, data lock needs a training delay
  always @(posedge core_clk)
  begin
    for (int c = 0; c < 4; c++)
    begin
      if (lockToData[c] !== 1'b1)
        cnt[c] = 0;
      else if (cnt[c] < LOCK_DLY)
        cnt[c] = cnt[c] + 1;
      pllLockDetect[c] <= (lockToData[c] !== 1'b1) || (cnt[c] >= LOCK_DLY);
    end
  end
endmodule
`default_nettype wire

/* File: tb/serdes_quad_rx_align_control_tb.sv */
// Self-checking bench for the quad receive alignment control block
`timescale 1ns/1ns
`default_nettype none
module serdes_quad_rx_align_control_tb;
  import serdes_align_pkg::*;
  localparam int LOCK_DLY = 12;
  logic core_clk = 1'b0;
  logic rst_n, regWr, regRd, rdWas;
  logic [19:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [3:0] pllLockDetect, byteSyncEnable, lockToData, lockIndicator, wordAlignDisable, wordRealignPulse;
  logic [3:0] serialLoopbackEnable, serialTxEnable, multichanParticipate, twinAlign, quadAlign;
  logic [3:0] alignResyncPulse, xauiLinkSelect;
  logic [19:0] regs [6] = '{OFS_SYNC_LOCK, OFS_LOOP_WALIGN, OFS_LINK_SM, OFS_REALIGN_PART, OFS_SYNC_MODE,
    OFS_RESYNC_LINK};
  logic [7:0] pulseVals [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h7F, 8'h80};
  logic [7:0] sh [logic [19:0]];
  logic [7:0] expQ [$];
  int nFail = 0;
  int checksDone = 0;
  int rlCnt [4], rsCnt [4], expRl [4], expRs [4];

  // Clock at 50 MHz
  always #10 core_clk = ~core_clk;

  serdes_quad_rx_align_control i_dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .pllLockDetect(pllLockDetect),
    .byteSyncEnable(byteSyncEnable), .lockToData(lockToData), .lockIndicator(lockIndicator),
    .wordAlignDisable(wordAlignDisable), .wordRealignPulse(wordRealignPulse),
    .serialLoopbackEnable(serialLoopbackEnable), .serialTxEnable(serialTxEnable),
    .multichanParticipate(multichanParticipate), .twinAlign(twinAlign), .quadAlign(quadAlign),
    .alignResyncPulse(alignResyncPulse), .xauiLinkSelect(xauiLinkSelect));

  lane_peer #(.LOCK_DLY(LOCK_DLY)) i_peer (.core_clk(core_clk), .lockToData(lockToData),
    .pllLockDetect(pllLockDetect));

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks made %0d, mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Bus idle cycles
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      regWr <= 1'b0;
      regRd <= 1'b0;
    end
  endtask

  // Register write, tracking the shadow and the pulses that rising bits should give
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    logic [7:0] rise;
    rise = sh.exists(a) ? (d & ~sh[a]) : 8'h00;
    for (int c = 0; c < 4; c++)
    begin
      if (a == OFS_REALIGN_PART)
        expRl[c] += int'(rise[c]);
      if (a == OFS_RESYNC_LINK)
        expRs[c] += int'(rise[c] | rise[(c < 2) ? 4 : 5] | rise[6]);
    end
    if (sh.exists(a))
      sh[a] = (a == OFS_LINK_SM) ? (d & 8'h0F) : d;
    @(posedge core_clk);
    regWr <= 1'b1;
    regRd <= 1'b0;
    regAddr <= a;
    regWrData <= d;
  endtask

  // Register read, the expected value goes on the queue
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regWr <= 1'b0;
    regAddr <= a;
  endtask

  task automatic clearShadow;
    foreach (regs[i])
      sh[regs[i]] = 8'h00;
  endtask

  function automatic logic [3:0] modeExp(input logic [7:0] m, input logic [3:0] p, input logic [1:0] code);
    logic [3:0] r;
    for (int c = 0; c < 4; c++)
      r[c] = p[c] && (m[2*c+:2] == code);
    return r;
  endfunction

  // Control outputs against the shadow registers
  task automatic chkOuts;
    logic [7:0] s0, s1, s2, s3;
    s0 = sh[OFS_SYNC_LOCK];
    s1 = sh[OFS_LOOP_WALIGN];
    s2 = sh[OFS_REALIGN_PART];
    s3 = sh[OFS_SYNC_MODE];
    check({4'h0, byteSyncEnable}, {4'h0, s0[3:0]});
    check({4'h0, lockToData}, {4'h0, s0[7:4]});
    check({4'h0, lockIndicator & ~s0[7:4]}, 8'h00);
    check({4'h0, serialLoopbackEnable}, {4'h0, s1[3:0]});
    check({4'h0, serialTxEnable}, {4'h0, ~s1[3:0]});
    check({4'h0, wordAlignDisable}, {4'h0, s1[7:4]});
    check({4'h0, multichanParticipate}, {4'h0, s2[7:4]});
    check({twinAlign, quadAlign}, {modeExp(s3, s2[7:4], SYNC_TWIN), modeExp(s3, s2[7:4], SYNC_QUAD)});
    check({4'h0, xauiLinkSelect}, {4'h0, sh[OFS_RESYNC_LINK][7] ? 4'hF : sh[OFS_LINK_SM][3:0]});
  endtask

  // Read data monitor and pulse counters
  always @(posedge core_clk)
  begin
    if (rdWas === 1'b1 && expQ.size() > 0)
      check(regRdData, expQ.pop_front());
    rdWas = regRd && rst_n;
    for (int c = 0; c < 4; c++)
    begin
      rlCnt[c] += int'(wordRealignPulse[c] === 1'b1);
      rsCnt[c] += int'(alignResyncPulse[c] === 1'b1);
    end
  end

  // Watchdog
  initial
  begin
    #(20 * 6000);
    nFail++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 20'h0_0000;
    regWrData = 8'h00;
    void'($urandom(88970));
    clearShadow();
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chkOuts();
    // Reset values, unmapped and read-only places
    foreach (regs[i])
      rd(regs[i], 8'h00);
    wr(20'h3_0803, 8'hA5);
    wr(OFS_LOCK_STAT, 8'hFF);
    rd(20'h3_0803, 8'h00);
    rd(OFS_LOCK_STAT, 8'h00);
    idle(2);
    // Random settings of every control register
    for (int it = 0; it < 8; it++)
    begin
      foreach (regs[i])
        wr(regs[i], 8'($urandom));
      idle(2);
      #1 chkOuts();
      idle(LOCK_DLY + 6);
      #1 check({4'h0, lockIndicator}, {4'h0, sh[OFS_SYNC_LOCK][7:4]});
      foreach (regs[i])
        rd(regs[i], sh[regs[i]]);
      rd(OFS_LOCK_STAT, {4'h0, sh[OFS_SYNC_LOCK][7:4]});
    end
    // Every sync mode code with all channels joined
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_REALIGN_PART, 8'hF0);
      wr(OFS_SYNC_MODE, {4{2'(m)}});
      idle(2);
      #1 chkOuts();
    end
    // Realign edges, steady levels, and each resync source back to back
    wr(OFS_REALIGN_PART, 8'h0F);
    wr(OFS_REALIGN_PART, 8'h0F);
    wr(OFS_REALIGN_PART, 8'h00);
    wr(OFS_REALIGN_PART, 8'h0F);
    foreach (pulseVals[i])
    begin
      wr(OFS_RESYNC_LINK, 8'h00);
      wr(OFS_RESYNC_LINK, pulseVals[i]);
      wr(OFS_RESYNC_LINK, pulseVals[i]);
    end
    idle(4);
    for (int c = 0; c < 4; c++)
    begin
      check(8'(rlCnt[c]), 8'(expRl[c]));
      check(8'(rsCnt[c]), 8'(expRs[c]));
    end
    // Second reset in mid-run clears everything
    rst_n <= 1'b0;
    clearShadow();
    idle(2);
    #1 chkOuts();
    @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (regs[i])
      rd(regs[i], 8'h00);
    idle(3);
    check(8'(expQ.size()), 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
